// >>> bench/rtcf_host.sv
// Host processor model on the byte-wide asynchronous bus
`timescale 1ns/10ps
module rtcf_host (
  input wire clock,
  input wire [7:0] data_out,
  input wire data_oe_n,
  output reg [16:0] addr,
  output reg [7:0] data_in,
  output reg chip_en_n,
  output reg write_en_n,
  output reg out_en_n
);
  initial begin
    addr = 17'h0_0000;
    data_in = 8'h00;
    {chip_en_n, write_en_n, out_en_n} = 3'b111;
  end
  // Read strobes held 12 clocks, write strobes 8, idle 10, above the filter's settle time
  task rd(input [16:0] a, output [7:0] d, output ok);
    integer i;
    begin
      @(negedge clock);
      addr = a;
      {chip_en_n, write_en_n, out_en_n} = 3'b010;
      ok = 0;
      d = 8'h00;
      for (i = 0; i < 12; i = i + 1) begin
        @(negedge clock);
        if (data_oe_n === 1'b0 && !ok) begin
          d = data_out;
          ok = 1;
        end
      end
      {chip_en_n, write_en_n, out_en_n} = 3'b111;
      repeat (10) @(negedge clock);
      addr = ~a;
    end
  endtask
  task wr(input [16:0] a, input [7:0] v);
    begin
      @(negedge clock);
      addr = a;
      data_in = v;
      {chip_en_n, write_en_n, out_en_n} = 3'b001;
      repeat (8) @(negedge clock);
      {chip_en_n, write_en_n, out_en_n} = 3'b111;
      repeat (10) @(negedge clock);
      addr = ~a;
      // Released bus shows the inverse, not a stale value
      data_in = ~v;
    end
  endtask
endmodule // rtcf_host

// >>> bench/rtcf_monitor.sv
// Port checks for the flag and control register block
`timescale 1ns/10ps
`include "rtcf_consts.vh"
module rtcf_monitor (
  input wire clock,
  input wire reset,
  input wire [16:0] addr,
  input wire [7:0] data_out,
  input wire data_oe_n,
  input wire write_en_n,
  input wire out_en_n,
  input wire int_normal,
  input wire int_pin,
  input wire freeze_clock,
  input wire load_base_time,
  input wire hold_time,
  input wire capture_time
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  wire flag_rd = addr == `RTCF_ADDR_FLAGS;
  sequence s_answer; $fell(data_oe_n); endsequence
  sequence s_cal_high; int_pin [*3]; endsequence
  a_answer_own: assert property (s_answer |-> flag_rd || addr == `RTCF_ADDR_CENTURY)
    else $error("answer on foreign address");
  a_answer_read: assert property (s_answer |-> !out_en_n && write_en_n)
    else $error("answer without read strobe");
  a_ctrl_readback: assert property (s_answer ##0 flag_rd |->
    data_out[1] == freeze_clock && data_out[0] == hold_time)
    else $error("control bits read back wrong");
  a_answer_stands: assert property (!data_oe_n && $past(!data_oe_n) |-> $stable(data_out))
    else $error("read data moved");
  a_load_single: assert property (load_base_time |-> !freeze_clock ##1 !load_base_time)
    else $error("bad load pulse");
  a_capture_single: assert property (capture_time |-> hold_time ##1 !capture_time)
    else $error("bad capture pulse");
  a_capture_on_rise: assert property ($rose(hold_time) |-> ##[0:1] capture_time)
    else $error("snapshot without capture");
  a_cal_half_wave: assert property ($rose(int_pin) && !int_normal |=> s_cal_high)
    else $error("calibration half period short");
endmodule // rtcf_monitor
bind rtcf_top rtcf_monitor rtcf_monitor_i (.clock, .reset, .addr, .data_out, .data_oe_n,
  .write_en_n, .out_en_n, .int_normal, .int_pin, .freeze_clock, .load_base_time, .hold_time,
  .capture_time);

// >>> bench/rtcf_top_tb_top.sv
// Bench for the flag, control and century registers
`timescale 1ns/10ps
`include "rtcf_consts.vh"
module rtcf_top_tb_top;
  reg clock, reset, dog_zero, supply_low, osc_running, century_carry, time_edited, int_normal;
  reg osc_enable;
  reg [31:0] time_now;
  reg [3:0] alarm_skip;
  reg [7:0] rdat;
  reg ok, last_int;
  wire [16:0] addr;
  wire [7:0] data_in, data_out;
  wire data_oe_n, chip_en_n, write_en_n, out_en_n, int_pin, freeze_clock, load_base_time;
  wire hold_time, capture_time;
  integer error_cnt, checked, loads, caps, flips, f0;
  localparam [16:0] FL = `RTCF_ADDR_FLAGS;
  localparam [16:0] CE = `RTCF_ADDR_CENTURY;
  rtcf_top #(.OSC_WAIT_CYC(20), .CAL_HALF_CYC(4)) rtcf_top_i (.clock, .reset, .addr, .data_in,
    .data_out, .data_oe_n, .chip_en_n, .write_en_n, .out_en_n, .dog_zero, .time_now,
    .alarm_value(32'h0000_0002), .alarm_skip, .supply_low, .osc_enable, .osc_running,
    .century_carry, .time_edited, .int_normal, .int_pin, .freeze_clock, .load_base_time,
    .hold_time, .capture_time);
  rtcf_host rtcf_host_i (.clock, .data_out, .data_oe_n, .addr, .data_in, .chip_en_n,
    .write_en_n, .out_en_n);
  initial begin
    clock = 0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    loads <= loads + (load_base_time === 1'b1);
    caps <= caps + (capture_time === 1'b1);
    flips <= flips + (int_pin !== last_int);
    last_int <= int_pin;
  end
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task rdc(input [16:0] a, input [7:0] exp);
    begin
      rtcf_host_i.rd(a, rdat, ok);
      cmp({ok, rdat}, {1'b1, exp});
    end
  endtask
  task wr(input [16:0] a, input [7:0] v);
    rtcf_host_i.wr(a, v);
  endtask
  task tally_and_finish;
    begin
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #(20 * 5000);
    error_cnt = error_cnt + 1;
    tally_and_finish;
  end
  initial begin
    {reset, dog_zero, supply_low, osc_running, century_carry, time_edited, int_normal} = 7'h40;
    time_now = 32'h0000_0001;
    alarm_skip = 4'h0;
    {error_cnt, checked, loads, caps, flips} = 0;
    last_int = 0;
    osc_enable = 1;
    repeat (10) @(negedge clock);
    reset = 0;
    repeat (30) @(negedge clock);
    rdc(FL, 8'h10);
    rdc(FL, 8'h10);
    $display("test power_up done");
    // Skipped seconds field lets a differing second still match
    {dog_zero, supply_low, alarm_skip} = 6'h31;
    time_now = 32'h0000_0003;
    @(negedge clock);
    {dog_zero, alarm_skip} = 5'h00;
    repeat (8) @(negedge clock);
    supply_low = 0;
    rdc(FL, 8'hF0);
    rdc(FL, 8'h10);
    $display("test events done");
    wr(CE, 8'h21);
    rdc(CE, 8'h00);
    // Bits 7..5 are read-only and bit 4 survives a locked write
    wr(FL, 8'hE2);
    cmp(freeze_clock, 1);
    rdc(FL, 8'h12);
    wr(CE, 8'h19);
    {century_carry, time_edited} = 2'h3;
    @(negedge clock);
    {century_carry, time_edited} = 2'h0;
    rdc(CE, 8'h19);
    wr(FL, 8'h00);
    cmp(loads, 1);
    rdc(FL, 8'h00);
    century_carry = 1;
    @(negedge clock);
    century_carry = 0;
    rdc(CE, 8'h20);
    $display("test edit done");
    wr(FL, 8'h01);
    cmp(caps, 1);
    rdc(FL, 8'h01);
    // Carry while held: reads keep the captured century
    century_carry = 1;
    @(negedge clock);
    century_carry = 0;
    rdc(CE, 8'h20);
    wr(FL, 8'h04);
    cmp(hold_time, 0);
    rdc(CE, 8'h21);
    rdc(FL, 8'h00);
    wr(FL, 8'h02);
    wr(FL, 8'h06);
    f0 = flips;
    repeat (40) @(negedge clock);
    cmp(flips - f0, 10);
    int_normal = 1;
    wr(FL, 8'h02);
    cmp(int_pin, 1);
    wr(FL, 8'h00);
    cmp(loads, 1);
    rtcf_host_i.rd(17'h1_FFF2, rdat, ok);
    cmp(ok, 0);
    $display("test control done");
    osc_running = 1;
    reset = 1;
    repeat (3) @(negedge clock);
    reset = 0;
    repeat (30) @(negedge clock);
    rdc(FL, 8'h00);
    rdc(CE, 8'h00);
    // Disabled oscillator never raises the crystal flag
    {osc_enable, osc_running} = 2'h0;
    reset = 1;
    repeat (3) @(negedge clock);
    reset = 0;
    repeat (30) @(negedge clock);
    rdc(FL, 8'h00);
    $display("test reset done");
    tally_and_finish;
  end
endmodule // rtcf_top_tb_top

// >>> hdl/rtcf_consts.vh
// Constants for the clock flag and control register block
// What this block does
// - Watchdog reaching zero unrestarted sets dog_expired_flag, bit 7; software cannot write it.
// - Time matching alarm on every unmasked field sets alarm_hit, bit 6.
// - Supply falling below switch threshold sets supply_drop_flag, bit 5; read-only.
// - Reading flag register clears bits 7..5; all three are zero after power-up.
// - After 5 ms, enabled oscillator never seen running sets crystal_stop_flag, bit 4.
// - crystal_stop_flag holds until software writes 0 while edit unlock is 1; reads never clear it.
// - Edit unlock bit 1 freezes clock and gates register writes; zero after power-up.
// - Writing edit unlock back to 0 loads edited time as new base time.
// - Snapshot bit 0 at 1 holds time for reads; 0 lets it follow; reset 0.
`ifndef RTCF_CONSTS_VH
`define RTCF_CONSTS_VH
`define RTCF_ADDR_FLAGS 17'h1_FFF0
`define RTCF_ADDR_CENTURY 17'h1_FFF1
`define RTCF_BIT_DOG 7
`define RTCF_BIT_ALARM 6
`define RTCF_BIT_SUPPLY 5
`define RTCF_BIT_XTAL 4
`define RTCF_BIT_CAL 2
`define RTCF_BIT_UNLOCK 1
`define RTCF_BIT_SNAP 0
`define RTCF_CENTURY_RESET 8'h00
`define RTCF_CLK_HZ 50000000
`define RTCF_OSC_WAIT_MS 5
`define RTCF_OSC_WAIT_CYC (`RTCF_CLK_HZ / 1000 * `RTCF_OSC_WAIT_MS)
`define RTCF_CAL_HZ 512
`define RTCF_CAL_HALF_CYC (`RTCF_CLK_HZ / (2 * `RTCF_CAL_HZ))
`endif

// >>> hdl/rtcf_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module rtcf_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire clock,
  input wire reset,
  input wire [WIDTH-1:0] pin,
  output reg [WIDTH-1:0] level
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  integer i;

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
      level <= INIT;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      // Only bits where stages two and three agree may change
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end
endmodule // rtcf_sync

// >>> hdl/rtcf_top.v
// Flag, control and century registers of the clock on the byte-wide bus
`timescale 1ns/10ps
`include "rtcf_consts.vh"
module rtcf_top #(
  parameter OSC_WAIT_CYC = `RTCF_OSC_WAIT_CYC,
  parameter CAL_HALF_CYC = `RTCF_CAL_HALF_CYC
) (
  input wire clock,
  input wire reset,
  input wire [16:0] addr,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output reg data_oe_n,
  input wire chip_en_n,
  input wire write_en_n,
  input wire out_en_n,
  input wire dog_zero,
  input wire [31:0] time_now,
  input wire [31:0] alarm_value,
  input wire [3:0] alarm_skip,
  input wire supply_low,
  input wire osc_enable,
  input wire osc_running,
  input wire century_carry,
  input wire time_edited,
  input wire int_normal,
  output reg int_pin,
  output wire freeze_clock,
  output reg load_base_time,
  output wire hold_time,
  output reg capture_time
);
  // Register select: 0 none, 1 flags, 2 century
  function [1:0] reg_sel;
    input [16:0] a;
    begin
      if (a == `RTCF_ADDR_FLAGS) begin
        reg_sel = 2'd1;
      end else if (a == `RTCF_ADDR_CENTURY) begin
        reg_sel = 2'd2;
      end else begin
        reg_sel = 2'd0;
      end
    end
  endfunction

  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9) begin
        bcd_inc = (v[7:4] == 4'h9) ? 8'h00 : {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction

  wire [2:0] strobes;
  wire [1:0] analog;
  wire sel_low;
  wire wr_low;
  wire oe_low;
  wire supply_s;
  wire osc_run_s;
  wire read_active;
  wire write_active;
  wire alarm_match;

  // Strobes idle high so reset must not look like an access
  rtcf_sync #(.WIDTH(3), .INIT(3'b111)) u_strobe_sync (
    .clock(clock),
    .reset(reset),
    .pin({chip_en_n, write_en_n, out_en_n}),
    .level(strobes)
  );

  rtcf_sync #(.WIDTH(2), .INIT(2'b00)) u_analog_sync (
    .clock(clock),
    .reset(reset),
    .pin({supply_low, osc_running}),
    .level(analog)
  );

  assign sel_low = ~strobes[2];
  assign wr_low = ~strobes[1];
  assign oe_low = ~strobes[0];
  assign supply_s = analog[1];
  assign osc_run_s = analog[0];
  assign read_active = sel_low & oe_low & ~wr_low;
  assign write_active = sel_low & wr_low;

  reg dog_flag;
  reg alarm_flag;
  reg supply_flag;
  reg xtal_flag;
  reg cal_on;
  reg unlock;
  reg snap;
  reg [7:0] century;
  reg [7:0] century_hold;
  reg dirty;
  reg read_q;
  reg write_q;
  reg [16:0] wr_addr;
  reg [7:0] wr_data;
  reg supply_q;
  reg match_q;
  reg [31:0] osc_count;
  reg osc_done;
  reg osc_seen;
  reg [31:0] cal_count;
  reg cal_wave;

  assign freeze_clock = unlock;
  assign hold_time = snap;

  // Skip bit 1 leaves that field out of the comparison
  assign alarm_match = (alarm_skip[0] | (time_now[7:0] == alarm_value[7:0]))
    & (alarm_skip[1] | (time_now[15:8] == alarm_value[15:8]))
    & (alarm_skip[2] | (time_now[23:16] == alarm_value[23:16]))
    & (alarm_skip[3] | (time_now[31:24] == alarm_value[31:24]));

  wire read_start = read_active & ~read_q;
  wire write_end = write_q & ~write_active;
  wire [1:0] rd_sel = reg_sel(addr);
  wire [1:0] wr_sel = reg_sel(wr_addr);
  wire flags_read = read_start & (rd_sel == 2'd1);
  wire flags_write = write_end & (wr_sel == 2'd1);
  wire century_write = write_end & (wr_sel == 2'd2) & unlock;
  // Match held for a whole second must set the flag only once
  wire alarm_event = alarm_match & ~match_q;
  wire supply_event = supply_s & ~supply_q;
  wire osc_window_end = ~osc_done && (osc_count == OSC_WAIT_CYC - 1);
  wire xtal_event = osc_window_end & osc_enable & ~osc_seen & ~osc_run_s;

  wire [7:0] flag_image = {dog_flag, alarm_flag, supply_flag, xtal_flag,
                           1'b0, cal_on, unlock, snap};

  // Bus edge tracking and write capture
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      read_q <= 1'b0;
      write_q <= 1'b0;
      wr_addr <= 17'h0_0000;
      wr_data <= 8'h00;
      supply_q <= 1'b0;
      match_q <= 1'b0;
    end else begin
      read_q <= read_active;
      write_q <= write_active;
      // Address and data are taken while the strobe is held low
      if (write_active) begin
        wr_addr <= addr;
        wr_data <= data_in;
      end
      supply_q <= supply_s;
      match_q <= alarm_match;
    end
  end

  // Read data and output enable
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
    end else begin
      if (read_start) begin
        case (rd_sel)
          2'd1: data_out <= flag_image;
          2'd2: data_out <= snap ? century_hold : century;
          default: data_out <= 8'h00;
        endcase
      end
      data_oe_n <= ~(read_active & (rd_sel != 2'd0));
    end
  end

  // Sticky event flags; a new event wins over the read clear
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      dog_flag <= 1'b0;
      alarm_flag <= 1'b0;
      supply_flag <= 1'b0;
      xtal_flag <= 1'b0;
    end else begin
      dog_flag <= dog_zero | (dog_flag & ~flags_read);
      alarm_flag <= alarm_event | (alarm_flag & ~flags_read);
      supply_flag <= supply_event | (supply_flag & ~flags_read);
      // Reads leave it alone; only a written 0 clears it
      if (xtal_event) begin
        xtal_flag <= 1'b1;
      end else if (flags_write && unlock && !wr_data[`RTCF_BIT_XTAL]) begin
        xtal_flag <= 1'b0;
      end
    end
  end

  // Oscillator start-up window after power-up
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      osc_count <= 32'h0000_0000;
      osc_done <= 1'b0;
      osc_seen <= 1'b0;
    end else if (!osc_done) begin
      osc_count <= osc_count + 32'h0000_0001;
      if (osc_run_s) begin
        osc_seen <= 1'b1;
      end
      if (osc_window_end) begin
        osc_done <= 1'b1;
      end
    end
  end

  // Control bits; unlock and snapshot stay writable so software can unlock
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      cal_on <= 1'b0;
      unlock <= 1'b0;
      snap <= 1'b0;
      load_base_time <= 1'b0;
      capture_time <= 1'b0;
      dirty <= 1'b0;
    end else begin
      load_base_time <= 1'b0;
      capture_time <= 1'b0;
      if (flags_write) begin
        unlock <= wr_data[`RTCF_BIT_UNLOCK];
        snap <= wr_data[`RTCF_BIT_SNAP];
        if (unlock) begin
          cal_on <= wr_data[`RTCF_BIT_CAL];
        end
        if (wr_data[`RTCF_BIT_SNAP] && !snap) begin
          capture_time <= 1'b1;
        end
        // New base time only when something was edited
        if (unlock && !wr_data[`RTCF_BIT_UNLOCK] && dirty) begin
          load_base_time <= 1'b1;
          dirty <= 1'b0;
        end
      end
      // An edit in the reload cycle must not be lost
      if (century_write || (time_edited && unlock)) begin
        dirty <= 1'b1;
      end
    end
  end

  // Century count, frozen while unlocked
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      century <= `RTCF_CENTURY_RESET;
      century_hold <= `RTCF_CENTURY_RESET;
    end else begin
      if (century_write) begin
        century <= wr_data;
      end else if (century_carry && !unlock) begin
        century <= bcd_inc(century);
      end
      if (!snap || (flags_write && wr_data[`RTCF_BIT_SNAP] && !snap)) begin
        century_hold <= century;
      end
    end
  end

  // Calibration square wave on the interrupt pin
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      cal_count <= 32'h0000_0000;
      cal_wave <= 1'b0;
      int_pin <= 1'b0;
    end else begin
      if (!cal_on) begin
        cal_count <= 32'h0000_0000;
        cal_wave <= 1'b0;
      end else if (cal_count == CAL_HALF_CYC - 1) begin
        cal_count <= 32'h0000_0000;
        cal_wave <= ~cal_wave;
      end else begin
        cal_count <= cal_count + 32'h0000_0001;
      end
      int_pin <= cal_on ? cal_wave : int_normal;
    end
  end
endmodule // rtcf_top
